/* hdl/rst_remap_pkg.sv */
package rst_remap_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on the AHB-Lite bus)
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_REMAP    = 32'hFFFF0220;
    localparam logic [31:0] ADDR_FLAGS    = 32'hFFFF0230;
    localparam logic [31:0] ADDR_CLEAR    = 32'hFFFF0234;
    localparam logic [31:0] ADDR_KEY1     = 32'hFFFF0248;
    localparam logic [31:0] ADDR_CFG      = 32'hFFFF024C;
    localparam logic [31:0] ADDR_KEY2     = 32'hFFFF0250;
    localparam logic [31:0] ADDR_IRQ_STAT = 32'hFFFF0260;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'hFFFF0264;

    // ------------------------------------------------------------------
    // Fields and values
    // ------------------------------------------------------------------
    localparam int          REMAP_BIT  = 0;
    localparam int          FLAG_POR   = 0;
    localparam int          FLAG_WDT   = 1;
    localparam int          FLAG_SW    = 2;
    localparam int          FLAG_W     = 3;
    localparam logic [2:0]  FLAGS_RST  = 3'h1;
    localparam int          CFG_GPIO   = 0;
    localparam int          CFG_DAC    = 2;
    localparam logic [7:0]  CFG_WMASK  = 8'h05;
    localparam logic [7:0]  CFG_RST    = 8'h00;
    localparam logic [7:0]  UNLOCK_KEY1 = 8'h76;
    localparam logic [7:0]  UNLOCK_KEY2 = 8'hB1;
    localparam int          IRQ_EXT    = 0;
    localparam int          IRQ_WDT    = 1;
    localparam int          IRQ_SW     = 2;
    localparam int          IRQ_CLRERR = 3;
    localparam int          IRQ_KEYERR = 4;
    localparam int          IRQ_W      = 5;
    localparam logic [31:0] VEC_BASE   = 32'h00000000;
    localparam logic [31:0] VEC_END    = 32'h00000020;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int RST_HOLD_NS   = 500;
    localparam int RST_HOLD_CYC  =
        (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] HOLD_LOAD = 4'(RST_HOLD_CYC - 1);

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_HOLD   = 2'b00,
        ST_KERNEL = 2'b01,
        ST_USER   = 2'b11
    } seq_state_e;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_GOT1 = 2'b01,
        KEY_GOTV = 2'b11
    } key_state_e;

endpackage

/* hdl/remap_if.sv */
interface remap_if;
    logic        remap;
    logic [31:0] cpu_addr;
    logic        sram_sel;
    logic        flash_sel;

    modport ctrl (output remap, output cpu_addr,
                  input sram_sel, input flash_sel);
    modport dec  (input remap, input cpu_addr,
                  output sram_sel, output flash_sel);
endinterface

/* hdl/remap_decode.sv */
module remap_decode
    import rst_remap_pkg::*;
(
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Remap selection and decode result
    remap_if.dec      rif
);

    typedef struct packed {
        logic sram_sel;
        logic flash_sel;
    } dec_s;

    dec_s st;
    dec_s next_st;
    logic vec_hit;

    always_comb begin
        vec_hit = (rif.cpu_addr >= VEC_BASE) && (rif.cpu_addr <= VEC_END);
        next_st.sram_sel  = vec_hit && rif.remap;
        next_st.flash_sel = vec_hit && !rif.remap;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rif.sram_sel  = st.sram_sel;
    assign rif.flash_sel = st.flash_sel;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_sram_mirror: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (rif.remap && rif.cpu_addr <= VEC_END) |=>
        rif.sram_sel && !rif.flash_sel)
        else $error("vector access not steered to sram");
    a_flash_mirror: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (!rif.remap && rif.cpu_addr <= VEC_END) |=>
        rif.flash_sel && !rif.sram_sel)
        else $error("vector access not steered to flash");
    a_outside_vec: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (rif.cpu_addr > VEC_END) |=> !rif.flash_sel && !rif.sram_sel)
        else $error("address above vector region redirected");

endmodule

/* hdl/rst_remap_ctrl.sv */
module rst_remap_ctrl
    import rst_remap_pkg::*;
(
    // Clock and power-on reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Reset sources
    input  wire logic        ext_reset_pin_n,
    input  wire logic        wdt_timeout,
    input  wire logic        boot_mode_pin,
    input  wire logic        kernel_done,
    // Reset outputs and boot sequencing
    output logic             system_reset_n,
    output logic             dac_reset_n,
    output logic             gpio_reset_n,
    output logic             kernel_active,
    output logic             user_vector_jump,
    // Address remap
    input  wire logic [31:0] cpu_addr,
    output logic             low_sram_sel,
    output logic             low_flash_sel,
    // Interrupt
    output logic             irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        seq_state_e         seq;
        logic [3:0]         hold_cnt;
        logic               full_rst;
        logic               sys_rst_n;
        logic               dac_rst_n;
        logic               gpio_rst_n;
        logic               jump;
        logic               remap;
        logic [FLAG_W-1:0]  flags;
        logic [7:0]         cfg;
        key_state_e         key;
        logic [7:0]         cfg_pend;
        logic [IRQ_W-1:0]   irq_stat;
        logic [IRQ_W-1:0]   irq_mask;
        logic [1:0]         ext_sync;
        logic [1:0]         bm_sync;
        logic               d_act;
        logic               d_write;
        logic [31:0]        d_addr;
        logic [31:0]        rdata;
    } state_s;

    state_s st;
    state_s next_st;

    logic             ext_low;
    logic             boot_normal;
    logic             addr_ok;
    logic             wr;
    logic             sw_req;
    logic             clr_wr;
    logic             clr_fault;
    logic             key_commit;
    logic             key_err;
    logic             reset_event;
    logic             soft_only;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_rdclr;
    logic [31:0]      rd_mux;

    remap_if rif ();

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Pins pass two flops; only the second stage is read.
        next_st.ext_sync = {st.ext_sync[0], ext_reset_pin_n};
        next_st.bm_sync  = {st.bm_sync[0], boot_mode_pin};
        ext_low     = !st.ext_sync[1];
        boot_normal = st.bm_sync[1];

        // Bus: address phase taken when selected, ready and NONSEQ or SEQ (htrans[1] set).
        addr_ok         = hsel && hready && htrans[1];
        next_st.d_act   = addr_ok;
        next_st.d_write = addr_ok && hwrite;
        next_st.d_addr  = addr_ok ? haddr : st.d_addr;
        wr              = st.d_act && st.d_write;

        unique case (haddr)
            ADDR_REMAP:    rd_mux = {31'h0, st.remap};
            ADDR_FLAGS:    rd_mux = {29'h0, st.flags};
            ADDR_CFG:      rd_mux = {24'h0, st.cfg};
            ADDR_IRQ_STAT: rd_mux = {27'h0, st.irq_stat};
            ADDR_IRQ_MASK: rd_mux = {27'h0, st.irq_mask};
            default:       rd_mux = 32'h0;
        endcase
        next_st.rdata = (addr_ok && !hwrite) ? rd_mux : st.rdata;
        irq_rdclr = (addr_ok && !hwrite && haddr == ADDR_IRQ_STAT)
                    ? st.irq_stat : '0;

        // Register writes in the data phase.
        sw_req    = wr && st.d_addr == ADDR_FLAGS &&
                    hwdata[FLAG_SW];
        clr_wr    = wr && st.d_addr == ADDR_CLEAR;
        // Any set flag left standing by the clear write forces a reset.
        clr_fault = clr_wr && |(st.flags & ~hwdata[FLAG_W-1:0]);
        if (wr && st.d_addr == ADDR_REMAP) begin
            next_st.remap = hwdata[REMAP_BIT];
        end
        if (wr && st.d_addr == ADDR_IRQ_MASK) begin
            next_st.irq_mask = hwdata[IRQ_W-1:0];
        end

        // Unlock sequence: key 1, value, key 2 as consecutive writes.
        key_commit = 1'b0;
        key_err    = 1'b0;
        if (wr) begin
            unique case (st.key)
                KEY_IDLE: begin
                    if (st.d_addr == ADDR_KEY1 &&
                        hwdata[7:0] == UNLOCK_KEY1) begin
                        next_st.key = KEY_GOT1;
                    end else if (st.d_addr == ADDR_CFG) begin
                        key_err = 1'b1;
                    end
                end
                KEY_GOT1: begin
                    if (st.d_addr == ADDR_CFG) begin
                        next_st.cfg_pend = hwdata[7:0] & CFG_WMASK;
                        next_st.key      = KEY_GOTV;
                    end else begin
                        key_err     = 1'b1;
                        next_st.key = KEY_IDLE;
                    end
                end
                KEY_GOTV: begin
                    next_st.key = KEY_IDLE;
                    if (st.d_addr == ADDR_KEY2 &&
                        hwdata[7:0] == UNLOCK_KEY2) begin
                        key_commit = 1'b1;
                    end else begin
                        key_err = 1'b1;
                    end
                end
                default: next_st.key = KEY_IDLE;
            endcase
        end
        if (key_commit) begin
            next_st.cfg = st.cfg_pend;
        end

        // Flags: clear first, then hardware sets, so a set is never lost.
        if (clr_wr) begin
            next_st.flags = st.flags & ~hwdata[FLAG_W-1:0];
        end
        if (wdt_timeout) begin
            next_st.flags[FLAG_WDT] = 1'b1;
        end
        if (sw_req) begin
            next_st.flags[FLAG_SW] = 1'b1;
        end

        // Reset causes. An external reset leaves no flag of its own.
        reset_event = ext_low || wdt_timeout ||
                      sw_req || clr_fault;
        soft_only   = !ext_low && !clr_fault;

        irq_set = '0;
        irq_set[IRQ_EXT]    = ext_low && st.seq != ST_HOLD;
        irq_set[IRQ_WDT]    = wdt_timeout;
        irq_set[IRQ_SW]     = sw_req;
        irq_set[IRQ_CLRERR] = clr_fault;
        irq_set[IRQ_KEYERR] = key_err;
        next_st.irq_stat = (st.irq_stat & ~irq_rdclr) | irq_set;

        // Reset sequencer.
        next_st.jump = 1'b0;
        if (reset_event) begin
            next_st.seq      = ST_HOLD;
            next_st.hold_cnt = HOLD_LOAD;
            next_st.remap    = 1'b0;
            next_st.key      = KEY_IDLE;
            // A fresh soft reset inside a hard one stays hard.
            next_st.full_rst = (st.seq == ST_HOLD && st.full_rst) ||
                               !soft_only;
        end else begin
            unique case (st.seq)
                ST_HOLD: begin
                    if (st.hold_cnt == '0) begin
                        next_st.seq = ST_KERNEL;
                    end else begin
                        next_st.hold_cnt = st.hold_cnt - 4'h1;
                    end
                end
                ST_KERNEL: begin
                    // Boot pin low keeps the core in the kernel.
                    if (kernel_done && boot_normal) begin
                        next_st.seq  = ST_USER;
                        next_st.jump = 1'b1;
                    end
                end
                ST_USER: begin
                    next_st.seq = ST_USER;
                end
                default: next_st.seq = ST_HOLD;
            endcase
        end

        next_st.sys_rst_n  = next_st.seq != ST_HOLD;
        next_st.dac_rst_n  = next_st.sys_rst_n ||
            (!next_st.full_rst && next_st.cfg[CFG_DAC]);
        next_st.gpio_rst_n = next_st.sys_rst_n ||
            (!next_st.full_rst && next_st.cfg[CFG_GPIO]);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st          <= '0;
            st.seq      <= ST_HOLD;
            st.hold_cnt <= HOLD_LOAD;
            st.full_rst <= 1'b1;
            st.flags    <= FLAGS_RST;
            st.cfg      <= CFG_RST;
            st.key      <= KEY_IDLE;
            st.ext_sync <= 2'h3;
            st.bm_sync  <= 2'h3;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign hrdata           = st.rdata;
    assign system_reset_n   = st.sys_rst_n;
    assign dac_reset_n      = st.dac_rst_n;
    assign gpio_reset_n     = st.gpio_rst_n;
    assign kernel_active    = st.seq == ST_KERNEL;
    assign user_vector_jump = st.jump;
    assign irq              = |(st.irq_stat & st.irq_mask);

    assign rif.remap    = st.remap;
    assign rif.cpu_addr = cpu_addr;
    assign low_sram_sel  = rif.sram_sel;
    assign low_flash_sel = rif.flash_sel;

    remap_decode u_remap_decode (
        .hclk    (hclk),
        .hresetn (hresetn),
        .rif     (rif)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_remap_cleared: assert property (@(posedge hclk)
        disable iff (!hresetn)
        reset_event |=> !st.remap ##1 !low_sram_sel)
        else $error("remap not cleared by reset");
    a_hold_length: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (reset_event && st.seq == ST_USER) |=> !system_reset_n [*5])
        else $error("system reset held too briefly");
    a_wdt_flag: assert property (@(posedge hclk)
        disable iff (!hresetn)
        wdt_timeout |=> st.flags[FLAG_WDT] && !system_reset_n)
        else $error("watchdog flag or reset missing");
    a_sw_reset: assert property (@(posedge hclk)
        disable iff (!hresetn)
        sw_req |=> st.flags[FLAG_SW] && !system_reset_n)
        else $error("software reset not taken");
    a_clear_fault: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (clr_wr && |(st.flags & ~hwdata[FLAG_W-1:0])) |=> !system_reset_n)
        else $error("partial clear did not reset");
    a_clear_flags: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (clr_wr && !wdt_timeout) |=>
        st.flags == ($past(st.flags) & ~$past(hwdata[FLAG_W-1:0])))
        else $error("flags not cleared as written");
    a_cfg_locked: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (st.cfg != $past(st.cfg)) |-> $past(key_commit))
        else $error("config changed without unlock");
    a_dac_keep: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (!system_reset_n && !st.full_rst) |-> dac_reset_n == st.cfg[CFG_DAC])
        else $error("dac retention wrong");
    a_gpio_keep: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (!system_reset_n && !st.full_rst) |->
        gpio_reset_n == st.cfg[CFG_GPIO])
        else $error("gpio retention wrong");
    a_hard_reset: assert property (@(posedge hclk)
        disable iff (!hresetn)
        (!system_reset_n && st.full_rst) |-> !dac_reset_n && !gpio_reset_n)
        else $error("hard reset kept peripheral state");
    a_kernel_first: assert property (@(posedge hclk)
        disable iff (!hresetn)
        $rose(user_vector_jump) |->
        $past(kernel_active) && $past(boot_normal))
        else $error("user vector entered without kernel");

    c_sw_reset: cover property (@(posedge hclk) disable iff (!hresetn)
        sw_req ##1 !system_reset_n);
    c_remap_on: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(st.remap));
    c_cfg_commit: cover property (@(posedge hclk) disable iff (!hresetn)
        key_commit);
    c_user_jump: cover property (@(posedge hclk) disable iff (!hresetn)
        user_vector_jump);
    c_boot_low: cover property (@(posedge hclk) disable iff (!hresetn)
        kernel_active && !boot_normal ##8 kernel_active);

endmodule

/* testbench/reset_src_model.sv */
module reset_src_model (
    // Clock, reset and sequencer state
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic kernel_active,
    // Requests from the bench
    input  wire logic wdt_req,
    input  wire logic ext_req,
    input  wire logic boot_low_req,
    // Reset sources
    output logic      wdt_timeout,
    output logic      ext_reset_pin_n,
    output logic      boot_mode_pin,
    output logic      kernel_done
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       wdt_q;
    logic [1:0] kcnt;

    initial begin
        wdt_timeout = 1'b0;
        ext_reset_pin_n = 1'b1;
        boot_mode_pin = 1'b1;
        kernel_done = 1'b0;
        wdt_q = 1'b0;
        kcnt = 2'h0;
    end

    // The core needs a few cycles of kernel code before it reports done.
    always @(posedge hclk) begin
        wdt_q <= wdt_req;
        wdt_timeout <= wdt_req & ~wdt_q;
        ext_reset_pin_n <= ~ext_req;
        boot_mode_pin <= ~boot_low_req;
        kcnt <= kernel_active ? kcnt + 2'h1 : 2'h0;
        kernel_done <= kernel_active && kcnt == 2'h2;
    end
endmodule

/* testbench/reset_source_and_remap_control_tb.sv */
module reset_source_and_remap_control_tb
    import rst_remap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, cpu_addr;
    logic [1:0]  htrans;
    logic        ext_reset_pin_n, wdt_timeout, boot_mode_pin, kernel_done;
    logic        system_reset_n, dac_reset_n, gpio_reset_n, kernel_active;
    logic        user_vector_jump, low_sram_sel, low_flash_sel, irq;
    logic        wdt_req, ext_req, boot_low_req;
    int          err_count, checks;

    rst_remap_ctrl u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .ext_reset_pin_n, .wdt_timeout, .boot_mode_pin,
        .kernel_done, .system_reset_n, .dac_reset_n, .gpio_reset_n,
        .kernel_active, .user_vector_jump, .cpu_addr, .low_sram_sel,
        .low_flash_sel, .irq);

    reset_src_model u_src (
        .hclk, .hresetn, .kernel_active, .wdt_req, .ext_req, .boot_low_req,
        .wdt_timeout, .ext_reset_pin_n, .boot_mode_pin, .kernel_done);

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (err_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [31:0] a, e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask

    task automatic sel(input logic [31:0] a, input logic s, f);
        @(posedge hclk);
        cpu_addr <= a;
        repeat (2) @(posedge hclk);
        #1;
        chk(low_sram_sel, s);
        chk(low_flash_sel, f);
    endtask

    // Kernel runs, then one jump pulse hands over to the user vector.
    task automatic boot();
        int n;
        n = 0;
        while (user_vector_jump !== 1'b1 && n < 60) begin
            @(posedge hclk);
            #1;
            n++;
        end
        chk(user_vector_jump, 1'b1);
        @(posedge hclk);
        #1;
        chk(kernel_active, 1'b0);
    endtask

    task automatic hit(input logic d, g);
        @(posedge hclk);
        #1;
        chk(system_reset_n, 1'b0);
        chk(dac_reset_n, d);
        chk(gpio_reset_n, g);
    endtask

    task automatic unlock(input logic [31:0] v);
        wr(ADDR_KEY1, 32'h76);
        wr(ADDR_CFG, v);
        wr(ADDR_KEY2, 32'hB1);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        boot();
        rd(ADDR_FLAGS, 32'h1);
        rd(ADDR_REMAP, 32'h0);
        rd(ADDR_CFG, 32'h0);
        rd(32'hFFFF0300, 32'h0);
        chk(hresp, 1'b0);
        sel(32'h0, 1'b0, 1'b1);
    endtask

    task automatic t_remap();
        sel(32'h00080024, 1'b0, 1'b0);
        wr(ADDR_REMAP, 32'h1);
        sel(32'h0, 1'b1, 1'b0);
        sel(VEC_END, 1'b1, 1'b0);
        sel(32'h24, 1'b0, 1'b0);
        wr(ADDR_REMAP, 32'h0);
        sel(32'h4, 1'b0, 1'b1);
    endtask

    // A lone config write is refused and flags a key error interrupt.
    task automatic t_keys();
        logic [31:0] r;
        bus(1'b0, ADDR_IRQ_STAT, 32'h0, r);
        wr(ADDR_IRQ_MASK, 32'h10);
        wr(ADDR_CFG, 32'h5);
        rd(ADDR_CFG, 32'h0);
        chk(irq, 1'b1);
        wr(ADDR_IRQ_MASK, 32'h0);
        #1;
        chk(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 32'h10);
        rd(ADDR_IRQ_STAT, 32'h10);
        #1;
        chk(irq, 1'b0);
        unlock(32'h5);
        rd(ADDR_CFG, 32'h5);
    endtask

    task automatic t_wdt();
        wr(ADDR_REMAP, 32'h1);
        @(posedge hclk);
        wdt_req <= 1'b1;
        repeat (2) @(posedge hclk);
        wdt_req <= 1'b0;
        hit(1'b1, 1'b1);
        boot();
        rd(ADDR_FLAGS, 32'h3);
        rd(ADDR_REMAP, 32'h0);
        sel(32'h0, 1'b0, 1'b1);
        wr(ADDR_CLEAR, 32'h3);
        rd(ADDR_FLAGS, 32'h0);
        chk(system_reset_n, 1'b1);
    endtask

    task automatic t_soft();
        unlock(32'h1);
        wr(ADDR_FLAGS, 32'h4);
        #1;
        chk(system_reset_n, 1'b0);
        hit(1'b0, 1'b1);
        boot();
        rd(ADDR_FLAGS, 32'h4);
        wr(ADDR_CLEAR, 32'h1);
        hit(1'b0, 1'b0);
        boot();
        wr(ADDR_CLEAR, 32'h4);
        rd(ADDR_FLAGS, 32'h0);
    endtask

    task automatic t_ext();
        @(posedge hclk);
        ext_req <= 1'b1;
        repeat (5) @(posedge hclk);
        ext_req <= 1'b0;
        hit(1'b0, 1'b0);
        boot();
        rd(ADDR_FLAGS, 32'h0);
        rd(ADDR_CFG, 32'h1);
    endtask

    // Boot pin low: the core stays in the kernel and never jumps.
    task automatic t_boot_low();
        @(posedge hclk);
        boot_low_req <= 1'b1;
        wdt_req <= 1'b1;
        repeat (2) @(posedge hclk);
        wdt_req <= 1'b0;
        repeat (20) begin
            @(posedge hclk);
            #1;
            chk(user_vector_jump, 1'b0);
        end
        chk(kernel_active, 1'b1);
        @(posedge hclk);
        boot_low_req <= 1'b0;
        boot();
        rd(ADDR_FLAGS, 32'h2);
        wr(ADDR_CLEAR, 32'h2);
        rd(ADDR_FLAGS, 32'h0);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        cpu_addr = 32'h0;
        wdt_req = 1'b0;
        ext_req = 1'b0;
        boot_low_req = 1'b0;
        err_count = 0;
        checks = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_remap();
        t_keys();
        t_wdt();
        t_soft();
        t_ext();
        t_boot_low();
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge hclk);
        err_count++;
        complete_run();
    end
endmodule
